// *** logic/itw_map.vh ***
// offsets, field positions, encodings and reset values of the thread and hazard control block
`ifndef ITW_MAP_VH
`define ITW_MAP_VH

// register byte offsets on the axi4-lite slave
`define ITW_CTRL_OFS        4'h0
`define ITW_YIELD_OFS       4'h4
`define ITW_STATUS_OFS      4'h8
`define ITW_COUNT_OFS       4'hC

// control register fields
`define ITW_CTRL_EN_BIT     0
`define ITW_CTRL_RST        1'b1

// yield delay register, reset value in cycles
`define ITW_YIELD_W         8
`define ITW_YIELD_RST       8'h10

// status register fields
`define ITW_ST_RSV_BIT      0
`define ITW_ST_CUR_LO       8

// instruction control word fields
`define ITW_TS_HI           15
`define ITW_TS_LO           14
`define ITW_NOCHK_BIT       11
`define ITW_NOCLR_BIT       10
`define ITW_WEOVR_BIT       9
`define ITW_CTRL_W          16

// thread switch encodings
`define ITW_TS_NORMAL       2'h0
`define ITW_TS_HOLD         2'h1
`define ITW_TS_YIELD        2'h2
`define ITW_TS_RSV          2'h3

// axi response codes
`define ITW_RESP_OKAY       2'h0
`define ITW_RESP_SLVERR     2'h2

`endif

// *** logic/itw_yield_tmr.v ***
// per-thread yield delay timer that blocks a thread after a forced switch
`timescale 1ns/1ps
module itw_yield_tmr #(
    parameter CW = 8
) (
    // clock and reset
    input  wire          i_clk,
    input  wire          i_resetn,
    // load strobe and length
    input  wire          i_load,
    input  wire [CW-1:0] i_len,
    // thread blocked while counting
    output wire          o_busy
);

    reg [CW-1:0] cnt_ff;   // cycles of delay left
    reg [CW-1:0] nxt_cnt;  // next count

    // load on yield dispatch, otherwise count down to zero
    always @* begin
        nxt_cnt = cnt_ff;
        if (i_load) begin
            nxt_cnt = i_len;
        end else if (cnt_ff != {CW{1'b0}}) begin
            nxt_cnt = cnt_ff - {{(CW-1){1'b0}}, 1'b1};
        end
    end

    // counter flop
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_ff <= {CW{1'b0}};
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign o_busy = (cnt_ff != {CW{1'b0}});

endmodule

// *** logic/itw_core.v ***
// thread switch, destination hazard and write enable control with axi4-lite registers
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`include "itw_map.vh"
module itw_core #(
    parameter NT   = 4,   // threads
    parameter TW   = 2,   // thread index width
    parameter PW   = 3,   // priority width
    parameter CH   = 16,  // execution channels
    parameter PLAT = 8    // execution pipe latency in cycles
) (
    // clock and reset
    input  wire                       i_clk,
    input  wire                       i_resetn,
    // axi4-lite write address and data
    input  wire [3:0]                 i_awaddr,
    input  wire                       i_awvalid,
    output wire                       o_awready,
    input  wire [31:0]                i_wdata,
    input  wire [3:0]                 i_wstrb,
    input  wire                       i_wvalid,
    output wire                       o_wready,
    // axi4-lite write response
    output reg  [1:0]                 o_bresp,
    output reg                        o_bvalid,
    input  wire                       i_bready,
    // axi4-lite read
    input  wire [3:0]                 i_araddr,
    input  wire                       i_arvalid,
    output wire                       o_arready,
    output reg  [31:0]                o_rdata,
    output reg  [1:0]                 o_rresp,
    output reg                        o_rvalid,
    input  wire                       i_rready,
    // per-thread head instruction
    input  wire [NT-1:0]              i_head_valid,
    input  wire [NT*`ITW_CTRL_W-1:0]  i_head_ctrl,
    input  wire [NT-1:0]              i_src_stall,
    input  wire [NT-1:0]              i_dst_busy,
    input  wire [NT*PW-1:0]           i_thr_prio,
    // dispatch to the execution pipe
    output reg                        o_issue_valid,
    output reg  [TW-1:0]              o_issue_thread,
    output reg                        o_issue_chk,
    output reg  [NT-1:0]              o_flush,
    // retirement of destination operands
    input  wire                       i_ret_valid,
    input  wire [`ITW_CTRL_W-1:0]     i_ret_ctrl,
    input  wire [CH-1:0]              i_ret_chan_we,
    input  wire [CH-1:0]              i_ret_pred_en,
    output reg                        o_sb_clear,
    output reg  [CH-1:0]              o_final_we
);

    // smallest yield delay that still exceeds the pipe latency
    localparam integer            YMIN_I = PLAT + 1;
    localparam [`ITW_YIELD_W-1:0] YMIN   = YMIN_I[`ITW_YIELD_W-1:0];  // cut to delay width

    // register state
    reg                     en_ff;        // dispatch enable
    reg [`ITW_YIELD_W-1:0]  ylen_ff;      // programmed yield delay
    reg                     rsv_ff;       // reserved switch code seen, sticky
    reg [31:0]              cnt_ff;       // dispatched instruction count
    reg [NT-1:0]            hold_ff;      // next instruction gets top priority
    reg [TW-1:0]            cur_ff;       // thread that issued last
    // axi capture state
    reg                     aw_ff;        // write address held
    reg                     w_ff;         // write data held
    reg [3:0]               awaddr_ff;    // held write address
    reg [31:0]              wdata_ff;     // held write data
    reg [3:0]               wstrb_ff;     // held byte strobes

    // arbitration signals
    wire [NT-1:0]           yblk;         // thread delayed after a yield
    reg  [NT-1:0]           rdy;          // thread may issue this cycle
    reg  [PW:0]             eprio;        // effective priority scratch
    reg  [PW:0]             best_p;       // best priority found
    reg  [PW:0]             cur_p;        // current thread priority
    reg  [TW-1:0]           best_t;       // best thread found
    reg  [TW-1:0]           sel;          // chosen thread
    reg                     any_rdy;      // some thread can issue
    reg  [`ITW_CTRL_W-1:0]  sctl;         // control word of chosen head
    reg  [`ITW_CTRL_W-1:0]  hctl;         // control word scratch
    reg  [NT-1:0]           yload;        // start yield timer per thread
    wire                    fire;         // dispatch this cycle
    wire [`ITW_YIELD_W-1:0] yeff;         // yield length used
    integer                 t;

    assign yeff = (ylen_ff < YMIN) ? YMIN : ylen_ff;

    // one delay timer per thread
    genvar g;
    generate
        for (g = 0; g < NT; g = g + 1) begin : g_ytmr
            itw_yield_tmr #(
                .CW     (`ITW_YIELD_W)
            ) u_tmr (
                .i_clk    (i_clk),
                .i_resetn (i_resetn),
                .i_load   (yload[g]),
                .i_len    (yeff),
                .o_busy   (yblk[g])
            );
        end
    endgenerate

    // readiness and priority arbitration over all threads
    always @* begin
        rdy     = {NT{1'b0}};
        best_p  = {(PW+1){1'b0}};
        best_t  = {TW{1'b0}};
        cur_p   = {(PW+1){1'b0}};
        any_rdy = 1'b0;
        eprio   = {(PW+1){1'b0}};
        hctl    = {`ITW_CTRL_W{1'b0}};
        for (t = 0; t < NT; t = t + 1) begin
            hctl = i_head_ctrl[t*`ITW_CTRL_W +: `ITW_CTRL_W];
            // a set skip bit drops the destination check
            rdy[t] = i_head_valid[t] & ~i_src_stall[t] & ~yblk[t]
                   & ~(i_dst_busy[t] & ~hctl[`ITW_NOCHK_BIT]);
            // held threads rank above every plain priority
            eprio = {hold_ff[t], i_thr_prio[t*PW +: PW]};
            if (t[TW-1:0] == cur_ff) begin
                cur_p = eprio;
            end
            if (rdy[t] && (!any_rdy || eprio > best_p)) begin
                best_p = eprio;
                best_t = t[TW-1:0];
            end
            any_rdy = any_rdy | rdy[t];
        end
        // stay on the current thread unless it stalls or is outranked
        if (rdy[cur_ff] && cur_p >= best_p) begin
            sel = cur_ff;
        end else begin
            sel = best_t;
        end
        sctl = i_head_ctrl[sel*`ITW_CTRL_W +: `ITW_CTRL_W];
    end

    assign fire = en_ff & any_rdy;

    // start the delay timer of a thread that issues a yield
    always @* begin
        yload = {NT{1'b0}};
        if (fire && sctl[`ITW_TS_HI:`ITW_TS_LO] == `ITW_TS_YIELD) begin
            yload[sel] = 1'b1;
        end
    end

    // dispatch stage and per-instruction thread control
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_issue_valid  <= 1'b0;
            o_issue_thread <= {TW{1'b0}};
            o_issue_chk    <= 1'b0;
            o_flush        <= {NT{1'b0}};
            hold_ff        <= {NT{1'b0}};
            cur_ff         <= {TW{1'b0}};
        end else begin
            o_issue_valid <= fire;
            o_flush       <= {NT{1'b0}};
            if (fire) begin
                o_issue_thread <= sel;
                cur_ff         <= sel;
                // check flag travels with only this instruction
                o_issue_chk    <= ~sctl[`ITW_NOCHK_BIT];
                // hold lasts for exactly the following instruction
                hold_ff[sel]   <= (sctl[`ITW_TS_HI:`ITW_TS_LO] == `ITW_TS_HOLD);
                // queue flush in the same cycle as the yielding dispatch
                if (sctl[`ITW_TS_HI:`ITW_TS_LO] == `ITW_TS_YIELD) begin
                    o_flush[sel] <= 1'b1;
                end
            end
        end
    end

    // retirement: scoreboard release and final channel write enables
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_sb_clear <= 1'b0;
            o_final_we <= {CH{1'b0}};
        end else begin
            // release suppressed only by the skip-release bit
            o_sb_clear <= i_ret_valid
                        & ~i_ret_ctrl[`ITW_NOCLR_BIT];
            if (!i_ret_valid) begin
                o_final_we <= {CH{1'b0}};
            end else if (i_ret_ctrl[`ITW_WEOVR_BIT]) begin
                o_final_we <= i_ret_pred_en;
            end else begin
                o_final_we <= i_ret_chan_we & i_ret_pred_en;
            end
        end
    end

    // axi write channels: address and data taken in either order
    assign o_awready = ~aw_ff & ~o_bvalid;
    assign o_wready  = ~w_ff & ~o_bvalid;
    assign o_arready = ~o_rvalid;

    // merge a byte-strobed write into a word
    function [31:0] itw_merge;
        input [31:0] old;
        input [31:0] dat;
        input [3:0]  stb;
        integer b;
        begin
            itw_merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (stb[b]) begin
                    itw_merge[b*8 +: 8] = dat[b*8 +: 8];
                end
            end
        end
    endfunction

    wire        wr_go = aw_ff & w_ff & ~o_bvalid;   // both halves present
    wire [31:0] yword = itw_merge({24'h0, ylen_ff}, wdata_ff, wstrb_ff);
    wire [31:0] cword = itw_merge({31'h0, en_ff}, wdata_ff, wstrb_ff);
    wire        rsv_hit = fire && sctl[`ITW_TS_HI:`ITW_TS_LO] == `ITW_TS_RSV;

    // write capture, register update and write response
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            aw_ff     <= 1'b0;
            w_ff      <= 1'b0;
            awaddr_ff <= 4'h0;
            wdata_ff  <= 32'h0000_0000;
            wstrb_ff  <= 4'h0;
            o_bvalid  <= 1'b0;
            o_bresp   <= `ITW_RESP_OKAY;
            en_ff     <= `ITW_CTRL_RST;
            ylen_ff   <= `ITW_YIELD_RST;
            rsv_ff    <= 1'b0;
            cnt_ff    <= 32'h0000_0000;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_ff     <= 1'b1;
                awaddr_ff <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                w_ff     <= 1'b1;
                wdata_ff <= i_wdata;
                wstrb_ff <= i_wstrb;
            end
            if (fire) begin
                cnt_ff <= cnt_ff + 32'h0000_0001;
            end
            // reserved switch code is flagged and handled as normal mode
            if (rsv_hit) begin
                rsv_ff <= 1'b1;
            end
            if (wr_go) begin
                aw_ff    <= 1'b0;
                w_ff     <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp  <= `ITW_RESP_OKAY;
                case (awaddr_ff)
                    `ITW_CTRL_OFS: begin
                        en_ff <= cword[`ITW_CTRL_EN_BIT];
                    end
                    `ITW_YIELD_OFS: begin
                        ylen_ff <= yword[`ITW_YIELD_W-1:0];
                    end
                    `ITW_STATUS_OFS: begin
                        // write one to clear; a new event wins
                        if (wstrb_ff[0] && wdata_ff[`ITW_ST_RSV_BIT] && !rsv_hit) begin
                            rsv_ff <= 1'b0;
                        end
                    end
                    `ITW_COUNT_OFS: begin
                        o_bresp <= `ITW_RESP_OKAY;
                    end
                    default: begin
                        o_bresp <= `ITW_RESP_SLVERR;
                    end
                endcase
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    // read channel: data registered one cycle after the address
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rvalid <= 1'b0;
            o_rdata  <= 32'h0000_0000;
            o_rresp  <= `ITW_RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            o_rvalid <= 1'b1;
            o_rresp  <= `ITW_RESP_OKAY;
            case (i_araddr)
                `ITW_CTRL_OFS: begin
                    o_rdata <= {31'h0, en_ff};
                end
                `ITW_YIELD_OFS: begin
                    o_rdata <= {24'h0, ylen_ff};
                end
                `ITW_STATUS_OFS: begin
                    o_rdata <= {{(24-TW){1'b0}}, cur_ff, 7'h00, rsv_ff};
                end
                `ITW_COUNT_OFS: begin
                    o_rdata <= cnt_ff;
                end
                default: begin
                    o_rdata <= 32'h0000_0000;
                    o_rresp <= `ITW_RESP_SLVERR;
                end
            endcase
        end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
        end
    end

endmodule

// *** test/itw_core_props.sv ***
// concurrent checks on dispatch and retirement outputs of the control block
`timescale 1ns/1ps
module itw_core_props #(
    parameter NT = 4,
    parameter TW = 2,
    parameter CH = 16
) (
    // clock and reset
    input wire             i_clk,
    input wire             i_resetn,
    // head instructions
    input wire [NT-1:0]    i_head_valid,
    input wire [NT*16-1:0] i_head_ctrl,
    input wire [NT-1:0]    i_src_stall,
    input wire [NT-1:0]    i_dst_busy,
    // dispatch
    input wire             o_issue_valid,
    input wire [TW-1:0]    o_issue_thread,
    input wire             o_issue_chk,
    input wire [NT-1:0]    o_flush,
    // retirement
    input wire             i_ret_valid,
    input wire [15:0]      i_ret_ctrl,
    input wire [CH-1:0]    i_ret_chan_we,
    input wire [CH-1:0]    i_ret_pred_en,
    input wire             o_sb_clear,
    input wire [CH-1:0]    o_final_we
);
    reg  [NT*16-1:0] ctrl_q;  // head words at the previous edge
    reg  [NT-1:0]    rdy_q;   // heads valid and free of source stall then
    reg  [NT-1:0]    busy_q;  // destinations busy then
    wire [15:0]      iw  = ctrl_q[o_issue_thread*16 +: 16];  // word of the issued head
    wire [NT-1:0]    one = {{(NT-1){1'b0}}, 1'b1} << o_issue_thread;  // issued thread as mask
    // keep the inputs that decided the dispatch seen now
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl_q <= {NT*16{1'b0}};
            rdy_q  <= {NT{1'b0}};
            busy_q <= {NT{1'b0}};
        end else begin
            ctrl_q <= i_head_ctrl;
            rdy_q  <= i_head_valid & ~i_src_stall;
            busy_q <= i_dst_busy;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    a_check_flag: assert property (o_issue_valid |-> o_issue_chk == !iw[11])
        else $error("check flag wrong");
    a_busy_blocks: assert property (o_issue_valid && o_issue_chk |-> !(busy_q & one))
        else $error("busy destination issued");
    a_stall_blocks: assert property (o_issue_valid |-> (rdy_q & one) != 0)
        else $error("unready head issued");
    a_yield_flush: assert property (o_issue_valid
        |-> o_flush == ((iw[15:14] == 2'h2) ? one : 0))
        else $error("flush wrong");
    a_flush_alone: assert property (o_flush != 0 |-> o_issue_valid)
        else $error("flush without issue");
    a_yield_delay: assert property (o_flush[0]
        |=> !(o_issue_valid && o_issue_thread == 0) [*8])
        else $error("yielded thread issued early");
    a_sb_release: assert property (i_ret_valid
        |=> o_sb_clear == !$past(i_ret_ctrl[10]))
        else $error("scoreboard release wrong");
    a_we_normal: assert property (i_ret_valid && !i_ret_ctrl[9]
        |=> o_final_we == ($past(i_ret_chan_we) & $past(i_ret_pred_en)))
        else $error("normal write enable wrong");
    a_we_override: assert property (i_ret_valid && i_ret_ctrl[9]
        |=> o_final_we == $past(i_ret_pred_en))
        else $error("override write enable wrong");
    a_ret_quiet: assert property (!i_ret_valid |=> !o_sb_clear && o_final_we == 0)
        else $error("retire output without retire");
    c_yield: cover property (o_flush != 0);
    c_no_check: cover property (o_issue_valid && !o_issue_chk);
    c_override: cover property (i_ret_valid && i_ret_ctrl[9]);
endmodule
bind itw_core itw_core_props #(.NT(NT), .TW(TW), .CH(CH)) u_props (.*);

// *** test/itw_istream.sv ***
// instruction stream model: per-thread queues feeding the head ports
`timescale 1ns/1ps
module itw_istream (
    // clock and reset
    input  wire        i_clk,
    input  wire        i_resetn,
    // word pushed by the bench
    input  wire        i_push,
    input  wire [1:0]  i_push_thr,
    input  wire [15:0] i_push_ctrl,
    // dispatch seen from the block
    input  wire        i_issue_valid,
    input  wire [1:0]  i_issue_thread,
    input  wire [3:0]  i_flush,
    // head of each queue
    output reg  [3:0]  o_head_valid,
    output reg  [63:0] o_head_ctrl
);
    reg [15:0] mem [0:31];  // eight words per thread
    reg [3:0]  rp [0:3];    // read pointers
    reg [3:0]  wp [0:3];    // write pointers
    reg [3:0]  idx;         // head index after a pending pop
    integer    t, u;        // thread loop indices
    // a dispatched head is popped at once so it is never offered twice
    always @* begin
        for (t = 0; t < 4; t = t + 1) begin
            idx = rp[t] + (i_issue_valid && i_issue_thread == t);
            o_head_valid[t] = (idx != wp[t]) && !i_flush[t];
            // an empty queue shows a scrambled word, never its last one
            o_head_ctrl[t*16 +: 16] = o_head_valid[t] ? mem[t*8+idx[2:0]] : ~mem[t*8+idx[2:0]];
        end
    end
    // queue pointers follow pushes, pops and flushes
    always @(posedge i_clk or negedge i_resetn) begin
        for (u = 0; u < 4; u = u + 1) begin
            if (!i_resetn) begin
                rp[u] <= 4'h0;
                wp[u] <= 4'h0;
            end else begin
                if (i_flush[u]) begin
                    rp[u] <= wp[u];
                end else if (i_issue_valid && i_issue_thread == u) begin
                    rp[u] <= rp[u] + 4'h1;
                end
                if (i_push && i_push_thr == u) begin
                    mem[u*8+wp[u][2:0]] <= i_push_ctrl;
                    wp[u] <= wp[u] + 4'h1;
                end
            end
        end
    end
endmodule

// *** test/itw_core_tb_top.sv ***
// self-checking bench for the thread, hazard and write enable control block
`timescale 1ns/1ps
module itw_core_tb_top;
    localparam PLAT = 8;  // pipe latency given to the block
    reg         i_clk, i_resetn, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    reg  [3:0]  i_awaddr, i_araddr, i_wstrb, i_src_stall, i_dst_busy;
    reg  [31:0] i_wdata, rd;
    reg  [11:0] i_thr_prio;
    reg         i_ret_valid, p_push, rv;
    reg  [15:0] i_ret_ctrl, i_ret_chan_we, i_ret_pred_en, p_ctrl, rc, rw, rp;
    reg  [1:0]  p_thr, rsp, it_t;
    wire        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_issue_valid, o_issue_chk;
    wire        o_sb_clear;
    wire [1:0]  o_bresp, o_rresp, o_issue_thread;
    wire [31:0] o_rdata;
    wire [3:0]  o_flush, i_head_valid;
    wire [63:0] i_head_ctrl;
    wire [15:0] o_final_we;
    integer     miscompares, checked, seed, k, w;
    itw_core #(.PLAT(PLAT)) uut (.*);
    itw_istream u_strm (.i_clk(i_clk), .i_resetn(i_resetn), .i_push(p_push), .i_push_thr(p_thr),
        .i_push_ctrl(p_ctrl), .i_issue_valid(o_issue_valid), .i_issue_thread(o_issue_thread),
        .i_flush(o_flush), .o_head_valid(i_head_valid), .o_head_ctrl(i_head_ctrl));
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    // value comparison
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            checked = checked + 1;
            if (g !== e) begin
                miscompares = miscompares + 1;
                $display("[FAIL] %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    // cycle span must exceed a bound
    task chk_gt(input string nm, input integer lo, input integer g);
        begin
            checked = checked + 1;
            if (!(g > lo)) begin
                miscompares = miscompares + 1;
                $display("[FAIL] %0s expected above %0d seen %0d", nm, lo, g);
            end
        end
    endtask
    task results;
        begin
            $display("comparisons %0d mismatches %0d", checked, miscompares);
            if (miscompares == 0 && checked > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask
    // register write, address and data offered together
    task axw(input [3:0] a, input [31:0] d);
        begin
            @(posedge i_clk);
            i_awaddr <= a;
            i_wdata <= d;
            i_awvalid <= 1'b1;
            i_wvalid <= 1'b1;
            i_bready <= 1'b1;
            do begin
                @(posedge i_clk);
                if (o_awready) i_awvalid <= 1'b0;
                if (o_wready) i_wvalid <= 1'b0;
            end while (!o_bvalid);
            rsp = o_bresp;
            i_bready <= 1'b0;
        end
    endtask
    // register read
    task axr(input [3:0] a);
        begin
            @(posedge i_clk);
            i_araddr <= a;
            i_arvalid <= 1'b1;
            i_rready <= 1'b1;
            do begin
                @(posedge i_clk);
                if (o_arready) i_arvalid <= 1'b0;
            end while (!o_rvalid);
            rd = o_rdata;
            rsp = o_rresp;
            i_rready <= 1'b0;
        end
    endtask
    // hand one control word to a thread queue
    task push(input [1:0] t, input [15:0] c);
        begin
            @(posedge i_clk);
            p_push <= 1'b1;
            p_thr <= t;
            p_ctrl <= c;
            @(posedge i_clk);
            p_push <= 1'b0;
        end
    endtask
    // wait for the next dispatch, w counts the cycles; outputs are read as they stood before the edge
    task wiss;
        begin
            w = 0;
            do begin
                @(posedge i_clk);
                w = w + 1;
            end while (!o_issue_valid && w < 60);
            it_t = o_issue_thread;
        end
    endtask
    // expected final write enables of one retire
    function [15:0] exp_we(input v, input [15:0] c, input [15:0] we, input [15:0] pe);
        exp_we = !v ? 16'h0 : (c[9] ? pe : we & pe);
    endfunction
    initial begin
        repeat (5000) @(posedge i_clk);
        miscompares = miscompares + 1;
        results;
    end
    initial begin
        {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_ret_valid, p_push} = 7'h0;
        {i_awaddr, i_araddr, i_wdata, i_src_stall, i_dst_busy, i_thr_prio} = 60'h0;
        {i_ret_ctrl, i_ret_chan_we, i_ret_pred_en, p_ctrl, p_thr} = 66'h0;
        i_wstrb = 4'hF;
        i_resetn = 1'b0;
        miscompares = 0;
        checked = 0;
        seed = 49;
        repeat (4) @(posedge i_clk);
        i_resetn <= 1'b1;
        axr(4'h0);
        chk("ctrl reset", 32'h1, rd);
        axr(4'h4);
        chk("yield reset", 32'h10, rd);
        axw(4'hC, 32'hFF);
        chk("count write resp", 32'h0, rsp);
        axw(4'h6, 32'h1);
        chk("unmapped write resp", 32'h2, rsp);
        axr(4'h2);
        chk("unmapped read resp", 32'h2, rsp);
        chk("unmapped read data", 32'h0, rd);
        $display("register test done");
        for (k = 0; k < 40; k = k + 1) begin
            @(posedge i_clk);
            rc = $random(seed);
            if (k < 4) rc[10:9] = k[1:0];
            {rw, rp} = $random(seed);
            rv = (k < 39);
            i_ret_valid <= rv;
            i_ret_ctrl <= rc;
            i_ret_chan_we <= rw;
            i_ret_pred_en <= rp;
            @(posedge i_clk);
            @(posedge i_clk);
            chk("sb clear", rv & ~rc[10], o_sb_clear);
            chk("final we", exp_we(rv, rc, rw, rp), o_final_we);
        end
        $display("retire test done");
        i_dst_busy <= 4'h6;
        push(2'h1, 16'h0000);
        push(2'h2, 16'h0800);
        wiss;
        chk("unchecked thread", 32'h2, {o_issue_chk, it_t});
        i_dst_busy <= 4'h0;
        wiss;
        chk("checked thread", 32'h5, {o_issue_chk, it_t});
        $display("hazard test done");
        i_thr_prio <= 12'hC29;
        i_src_stall <= 4'h3;
        push(2'h0, 16'h4000);
        push(2'h0, 16'h0000);
        push(2'h0, 16'h0000);
        push(2'h1, 16'h0000);
        i_src_stall <= 4'h2;
        // thread 1 frees up as the held word issues, so only the hold keeps thread 0 next
        @(posedge i_clk);
        i_src_stall <= 4'h0;
        for (k = 0; k < 4; k = k + 1) begin
            wiss;
            chk("arbitration", k == 2, it_t);
        end
        $display("priority test done");
        for (k = 0; k < 2; k = k + 1) begin
            if (k == 1) axw(4'h4, 32'h2);
            i_src_stall <= 4'h1;
            push(2'h0, 16'h8000);
            push(2'h0, 16'h0000);
            i_src_stall <= 4'h0;
            wiss;
            chk("yield flush", 32'h1, o_flush);
            push(2'h0, 16'h0000);
            wiss;
            chk_gt("yield gap", PLAT, w + 2);
            chk("yield gap exact", (k == 0) ? 32'h11 : PLAT + 2, w + 2);
        end
        $display("yield test done");
        push(2'h2, 16'hC000);
        wiss;
        axr(4'h8);
        chk("reserved seen", 32'h201, rd);
        axw(4'h8, 32'h1);
        axr(4'h8);
        chk("reserved cleared", 32'h200, rd);
        axr(4'hC);
        chk("dispatch count", 32'hB, rd);
        $display("reserved test done");
        results;
    end
endmodule
